// >>> hw/pmhs_pkg.sv
// Package for the power-management and hot-swap capability register bank
package pmhs_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Byte offsets in configuration space
    localparam logic [7:0] OFS_PM_NEXT = 8'hDD;
    localparam logic [7:0] OFS_PSCS_LO = 8'hE0;
    localparam logic [7:0] OFS_PSCS_HI = 8'hE1;
    localparam logic [7:0] OFS_BRIDGE_SUP = 8'hE2;
    localparam logic [7:0] OFS_OPDATA = 8'hE3;
    localparam logic [7:0] OFS_HOTSWAP_CAP_ID = 8'hE4;
    localparam logic [7:0] OFS_HOTSWAP_NEXT = 8'hE5;

    // Field positions
    localparam int PS_LSB = 0;
    localparam int PS_MSB = 1;
    localparam int SUP_BPCC_BIT = 7;
    localparam int SUP_B2B3_BIT = 6;

    // Values
    localparam logic [15:0] PSCS_RESET = 16'h0000;
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D1 = 2'h1;
    localparam logic [1:0] PS_D2 = 2'h2;
    localparam logic [1:0] PS_D3HOT = 2'h3;
    localparam logic [7:0] OPDATA_VALUE = 8'h00;
    localparam logic [7:0] HOTSWAP_CAP_ID_DEFAULT = 8'h06;
    localparam logic [7:0] HOTSWAP_CAP_ID_COMPAT = 8'h00;
    localparam logic [7:0] HOTSWAP_NEXT_VALUE = 8'h00;
    localparam logic [7:0] PM_NEXT_CHASSIS = 8'hE4;
    localparam logic [7:0] PM_NEXT_OTHER = 8'h00;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } pmhs_req_t;

    // Pins caught through two flip-flops
    typedef struct packed {
        logic strap;
        logic chassis_mode;
        logic compat_mode;
    } pmhs_pins_t;

endpackage : pmhs_pkg

// >>> hw/pmhs_regs.sv
// Power-management control/status and hot-swap capability header registers
`timescale 1ns/1ps
`default_nettype none

//Contract
//- The power-state word keeps its value across the internal reset issued on the D3hot to D0 move.
//- Bits 1-0 of the power-state word are read/write and encode D0, D1, D2 and D3hot as 00 to 11.
//- Wake-event status bit 15 always reads 0.
//- Wake-enable bit 8 is read-only and reads 0.
//- Data-scale bits 14-13 are read-only and read 00b.
//- Data-select bits 12-9 are read-only and read 0000b.
//- Reserved bits 7-2 of the power-state word read as zeros.
//- Bridge-support bit 7 mirrors the bus-control strap, two clk_sys cycles late through the two synchronizer flops.
//- Bridge-support bit 6 mirrors the strap, and when 1 the secondary clocks stop in D3hot.
//- Secondary clocks stop whenever the primary clock stops, whatever the power state; sec_clk_run only drops in D3hot with the strap set.
//- The operating-data byte is unimplemented and reads 00h.
//- The hot-swap capability ID reads 06h normally and 00h in the compatible mode.
//- The hot-swap next-item pointer is read-only and reads zero.
//- The power-management next-item pointer reads E4h in hot-swap chassis mode and 00h otherwise.
module pmhs_regs (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [pmhs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pmhs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pmhs_pkg::DATA_W-1:0] reg_rdata,
    input wire logic bus_control_strap_input,
    input wire logic hotswap_chassis_mode,
    input wire logic hotswap_compat_mode,
    output logic [1:0] power_state,
    output logic sec_clk_run,
    output logic func_reset_pulse
);

    pmhs_pkg::pmhs_req_t req;
    pmhs_pkg::pmhs_pins_t pins_raw;
    pmhs_pkg::pmhs_pins_t sync1_reg;
    pmhs_pkg::pmhs_pins_t sync2_reg;
    logic [1:0] ps_reg;
    logic [1:0] ps_next;
    logic [pmhs_pkg::DATA_W-1:0] rdata_reg;
    logic [pmhs_pkg::DATA_W-1:0] rdata_next;
    logic run_reg;
    logic run_next;
    logic freset_reg;
    logic freset_next;

    wire logic ps_write;
    wire logic [15:0] pscs_word;
    wire logic [7:0] bridge_sup;
    wire logic [7:0] hotswap_id;
    wire logic [7:0] pm_next;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign pins_raw = '{strap: bus_control_strap_input, chassis_mode: hotswap_chassis_mode,
                        compat_mode: hotswap_compat_mode};

    // Only the low byte of the power-state word holds writable bits
    assign ps_write = req.wr && (req.addr == pmhs_pkg::OFS_PSCS_LO);
    assign ps_next = ps_write ? req.wdata[pmhs_pkg::PS_MSB:pmhs_pkg::PS_LSB] : ps_reg;

    // Upper fields and reserved bits are constant zero
    assign pscs_word = {1'b0, 2'b00, 4'h0, 1'b0, 6'h00, ps_reg};

    assign bridge_sup = {sync2_reg.strap, sync2_reg.strap, 6'h00};
    assign hotswap_id = sync2_reg.compat_mode ? pmhs_pkg::HOTSWAP_CAP_ID_COMPAT
                                              : pmhs_pkg::HOTSWAP_CAP_ID_DEFAULT;
    assign pm_next = sync2_reg.chassis_mode ? pmhs_pkg::PM_NEXT_CHASSIS
                                            : pmhs_pkg::PM_NEXT_OTHER;

    function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [15:0] pw, input logic [7:0] bs,
                                            input logic [7:0] cid, input logic [7:0] pn);
        logic [7:0] v;
        v = pmhs_pkg::UNMAPPED_VALUE;
        case (a)
            pmhs_pkg::OFS_PM_NEXT: v = pn;
            pmhs_pkg::OFS_PSCS_LO: v = pw[7:0];
            pmhs_pkg::OFS_PSCS_HI: v = pw[15:8];
            pmhs_pkg::OFS_BRIDGE_SUP: v = bs;
            pmhs_pkg::OFS_OPDATA: v = pmhs_pkg::OPDATA_VALUE;
            pmhs_pkg::OFS_HOTSWAP_CAP_ID: v = cid;
            pmhs_pkg::OFS_HOTSWAP_NEXT: v = pmhs_pkg::HOTSWAP_NEXT_VALUE;
            default: v = pmhs_pkg::UNMAPPED_VALUE;
        endcase
        return v;
    endfunction : read_mux

    // Read data stand for exactly one cycle after the strobe
    assign rdata_next = req.rd ? read_mux(req.addr, pscs_word, bridge_sup, hotswap_id, pm_next)
                               : pmhs_pkg::UNMAPPED_VALUE;

    // Gating is on the primary clock, so a stopped primary freezes everything
    assign run_next = !(sync2_reg.strap && (ps_reg == pmhs_pkg::PS_D3HOT));

    // Internal function reset; it does not touch ps_reg
    assign freset_next = ps_write && (ps_reg == pmhs_pkg::PS_D3HOT)
                         && (req.wdata[pmhs_pkg::PS_MSB:pmhs_pkg::PS_LSB] == pmhs_pkg::PS_D0);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // Only the external reset clears the power state
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ps_reg <= pmhs_pkg::PSCS_RESET[1:0];
            rdata_reg <= '0;
            run_reg <= 1'b1;
            freset_reg <= 1'b0;
        end
        else
        begin
            ps_reg <= ps_next;
            rdata_reg <= rdata_next;
            run_reg <= run_next;
            freset_reg <= freset_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign power_state = ps_reg;
    assign sec_clk_run = run_reg;
    assign func_reset_pulse = freset_reg;

endmodule : pmhs_regs

`default_nettype wire

// >>> verification/pmhs_regs_sva.sv
// Checker for the capability register bank
`timescale 1ns/1ps
`default_nettype none
module pmhs_regs_sva (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic bus_control_strap_input,
    input wire logic hotswap_chassis_mode,
    input wire logic hotswap_compat_mode,
    input wire logic [1:0] power_state,
    input wire logic sec_clk_run,
    input wire logic func_reset_pulse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire logic wr_ps = reg_wr && reg_addr == 8'hE0;
    sequence s_wake; power_state == 2'h3 ##0 wr_ps && reg_wdata[1:0] == 2'h0; endsequence
    AST_WR: assert property (wr_ps |=> power_state == $past(reg_wdata[1:0])) else $error("write lost");
    AST_HOLD: assert property (!wr_ps |=> $stable(power_state)) else $error("state moved");
    AST_LO: assert property (reg_rd && reg_addr == 8'hE0 |=> reg_rdata[7:2] == 6'h00) else $error("reserved");
    AST_HI: assert property (reg_rd && reg_addr == 8'hE1 |=> reg_rdata == 8'h00) else $error("high byte");
    AST_NXT: assert property (reg_rd && reg_addr == 8'hE5 |=> reg_rdata == 8'h00) else $error("next ptr");
    AST_SEC: assert property (power_state != 2'h3 |=> sec_clk_run) else $error("clock stop");
    AST_WAKE: assert property (s_wake |=> func_reset_pulse ##1 !func_reset_pulse) else $error("no pulse");
    AST_PLS: assert property (func_reset_pulse |-> $past(power_state) == 2'h3) else $error("stray pulse");
endmodule : pmhs_regs_sva
bind pmhs_regs pmhs_regs_sva u_sva (.*);
`default_nettype wire

// >>> verification/pmhs_regs_tb.sv
// Bench for the capability register bank
`timescale 1ns/1ps
`default_nettype none
module pmhs_regs_tb;
    logic clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic bus_control_strap_input = 1'b0, hotswap_chassis_mode = 1'b0, hotswap_compat_mode = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    wire logic [7:0] reg_rdata;
    wire logic [1:0] power_state;
    wire logic sec_clk_run, func_reset_pulse;
    int mismatches = 0, checked = 0, cycles = 0;
    pmhs_regs dut (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        mismatches += int'(g !== e);
        if (g !== e) $display("ERROR %s expected %h seen %h", n, e, g);
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'b00;
        #1;
        if (!w) chk("rdata", d, reg_rdata);
        else if (a == 8'hE0) chk("state", d & 8'h03, 8'(power_state));
    endtask : acc
    task automatic end_of_test;
        mismatches += int'(cycles >= 2000);
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge clk_sys)
        if (++cycles == 2000) end_of_test();
    initial
    begin
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int s = 0; s < 4; s++) acc(1'b1, 8'hE0, 8'hFC | 8'(s));
        acc(1'b0, 8'hE0, 8'h03);
        acc(1'b1, 8'hE1, 8'hFF);
        for (int i = 0; i < 4; i++) acc(1'b0, 8'hE1 + 8'(2 * i), 8'h00);
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk_sys);
            {bus_control_strap_input, hotswap_chassis_mode, hotswap_compat_mode} <= {3{m[0]}};
            repeat (3) @(posedge clk_sys); // Pins pass two sync flops
            acc(1'b0, 8'hE2, m ? 8'hC0 : 8'h00);
            acc(1'b0, 8'hE4, m ? 8'h00 : 8'h06);
            acc(1'b0, 8'hDD, m ? 8'hE4 : 8'h00);
            chk("sec_clk_run", 8'(m == 0), 8'(sec_clk_run));
        end
        acc(1'b1, 8'hE0, 8'h00);
        chk("func_reset_pulse", 8'h01, 8'(func_reset_pulse));
        @(posedge clk_sys);
        #1;
        chk("func_reset_pulse", 8'h00, 8'(func_reset_pulse));
        chk("sec_clk_run", 8'h01, 8'(sec_clk_run));
        acc(1'b0, 8'hE0, 8'h00);
        end_of_test();
    end
endmodule : pmhs_regs_tb
`default_nettype wire
